/* hdl/iod_top.sv */
// Purpose: Decodes the 64-location I/O space for the processor core.
// Assumes: One request at a time; the core holds off while busy.
// Notes:   Extended data addresses are passed to an outside port.
module iod_top (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire iod_pkg::iod_req_t    req,
	output iod_pkg::iod_ans_t         ans,
	output logic                      busy,
	input  wire iod_pkg::iod_events_t events,
	input  wire logic [7:0]           port_b_pins,
	input  wire logic [6:0]           port_c_pins,
	input  wire logic [7:0]           port_d_pins,
	input  wire logic                 cmp_level,
	output iod_pkg::iod_ctrl_t        ctrl,
	output logic [1:0]                force_cmp,
	output logic                      ext_req,
	output logic                      ext_we,
	output logic [7:0]                ext_addr,
	output logic [7:0]                ext_wdata,
	input  wire logic [7:0]           ext_rdata
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]        io_ff [64];
	logic [7:0]        nxt_io [64];
	iod_pkg::iod_ans_t ans_ff;
	logic [1:0]        force_ff;
	logic              ext_req_ff;
	logic              ext_we_ff;
	logic [7:0]        ext_addr_ff;
	logic [7:0]        ext_wdata_ff;
	logic [23:0]       pins_sync;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	iod_pin_sync #(
		.WIDTH (24)
	) u_pin_sync (
		.clk     (clk),
		.rstn    (rstn),
		.pin_in  ({cmp_level, port_d_pins, port_c_pins, port_b_pins}),
		.pin_out (pins_sync)
	);

	// ------------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------------
	logic       take;
	logic       op_io;
	logic       op_bit;
	logic       op_skip;
	logic       op_mem;
	logic       mem_io;
	logic       mem_ext;
	logic       bit_ok;
	logic       do_write;
	logic       do_read;
	logic [5:0] addr;
	logic [7:0] data_rel;

	always_comb begin
		take     = req.valid && !ext_req_ff;
		op_io    = req.op == iod_pkg::io_read_op
			|| req.op == iod_pkg::io_write_op;
		op_bit   = req.op == iod_pkg::set_io_bit_op
			|| req.op == iod_pkg::clear_io_bit_op;
		op_skip  = req.op == iod_pkg::skip_when_io_bit_high
			|| req.op == iod_pkg::skip_when_io_bit_low;
		op_mem   = req.op == iod_pkg::memory_read_direct
			|| req.op == iod_pkg::memory_write_direct;
		data_rel = req.data_addr - iod_pkg::DATA_IO_OFFSET;
		mem_io   = op_mem && req.data_addr >= iod_pkg::DATA_IO_OFFSET
			&& req.data_addr <= iod_pkg::DATA_IO_LAST;
		// Only load/store reaches the extended window.
		mem_ext  = op_mem
			&& req.data_addr >= iod_pkg::DATA_EXT_FIRST;
		// A 6-bit field cannot name more than 64 locations.
		addr     = op_mem ? data_rel[5:0] : req.io_addr;
		bit_ok   = addr <= iod_pkg::BIT_SPAN_LAST;
		do_write = take && (req.op == iod_pkg::io_write_op
			|| (req.op == iod_pkg::memory_write_direct && mem_io)
			|| (op_bit && bit_ok));
		do_read  = take && (req.op == iod_pkg::io_read_op
			|| (req.op == iod_pkg::memory_read_direct && mem_io));
	end

	// ------------------------------------------------------------------
	// Write value of the addressed location
	// ------------------------------------------------------------------
	logic [7:0] sel_mask;
	logic [7:0] alu_val;
	logic       bit_test;

	iod_bit_alu u_bit_alu (
		.old_val  (io_ff[addr]),
		.rw_bits  (iod_pkg::rw_mask(addr)),
		.w1c_bits (iod_pkg::w1c_mask(addr)),
		.bit_mode (op_bit),
		.bit_set  (req.op == iod_pkg::set_io_bit_op),
		.bit_sel  (req.bit_sel),
		.wdata    (req.wdata),
		.sel_mask (sel_mask),
		.new_val  (alu_val),
		.bit_test (bit_test)
	);

	// ------------------------------------------------------------------
	// Hardware events and live levels
	// ------------------------------------------------------------------
	function automatic logic [7:0] live_bits(input logic [5:0] a,
			input logic [23:0] p);
		case (a)
			iod_pkg::OFS_PORT_B_PIN:    live_bits = p[7:0];
			iod_pkg::OFS_PORT_C_PIN:    live_bits = {1'b0, p[14:8]};
			iod_pkg::OFS_PORT_D_PIN:    live_bits = p[22:15];
			iod_pkg::OFS_CMP_CTL_STATE: live_bits = {2'b00, p[23], 5'h00};
			default:                    live_bits = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] event_bits(input logic [5:0] a,
			input iod_pkg::iod_events_t e);
		case (a)
			iod_pkg::OFS_T0_FLAGS:
				event_bits = {5'h00, e.t0_cmp_b, e.t0_cmp_a, e.t0_ovf};
			iod_pkg::OFS_T2_FLAGS:
				event_bits = {5'h00, e.t2_cmp_b, e.t2_cmp_a, e.t2_ovf};
			iod_pkg::OFS_SPI_STATE:
				event_bits = {e.spi_done, e.spi_collide, 6'h00};
			iod_pkg::OFS_CMP_CTL_STATE:
				event_bits = {3'h0, e.cmp_edge, 4'h0};
			default:
				event_bits = 8'h00;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Register array
	// ------------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			nxt_io[i] = io_ff[i];
			if (do_write && addr == 6'(i)) begin
				nxt_io[i] = alu_val;
			end
			// Stored bits only; reserved ones stay zero.
			nxt_io[i] = (nxt_io[i] & (iod_pkg::rw_mask(6'(i))
				| iod_pkg::w1c_mask(6'(i))))
				| live_bits(6'(i), pins_sync);
			// An event in the clearing cycle survives the clear.
			nxt_io[i] = nxt_io[i] | event_bits(6'(i), events);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 64; i++) begin
				io_ff[i] <= iod_pkg::REG_RESET;
			end
		end else begin
			for (int i = 0; i < 64; i++) begin
				io_ff[i] <= nxt_io[i];
			end
		end
	end

	// ------------------------------------------------------------------
	// Strobes of the write-only force bits
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			force_ff <= 2'b00;
		end else if (do_write && addr == iod_pkg::OFS_T0_CTL_B
				&& !op_bit) begin
			force_ff <= {req.wdata[iod_pkg::POS_FORCE_A],
				req.wdata[iod_pkg::POS_FORCE_B]};
		end else begin
			force_ff <= 2'b00;
		end
	end

	// ------------------------------------------------------------------
	// Extended window port
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_req_ff   <= 1'b0;
			ext_we_ff    <= 1'b0;
			ext_addr_ff  <= 8'h00;
			ext_wdata_ff <= 8'h00;
		end else begin
			ext_req_ff <= take && mem_ext;
			if (take && mem_ext) begin
				ext_we_ff    <= req.op == iod_pkg::memory_write_direct;
				ext_addr_ff  <= req.data_addr;
				ext_wdata_ff <= req.wdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// Answer to the core
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ans_ff <= '0;
		end else begin
			ans_ff <= '0;
			if (ext_req_ff) begin
				ans_ff.ack   <= 1'b1;
				ans_ff.rdata <= ext_we_ff ? 8'h00 : ext_rdata;
			end else if (take && !mem_ext) begin
				ans_ff.ack     <= 1'b1;
				ans_ff.rdata   <= do_read ? io_ff[addr] : 8'h00;
				ans_ff.refused <= (op_bit || op_skip) && !bit_ok;
				if (op_skip && bit_ok) begin
					ans_ff.skip <= bit_test
						== (req.op == iod_pkg::skip_when_io_bit_high);
				end
			end
		end
	end

	assign ans       = ans_ff;
	assign busy      = ext_req_ff;
	assign force_cmp = force_ff;
	assign ext_req   = ext_req_ff;
	assign ext_we    = ext_we_ff;
	assign ext_addr  = ext_addr_ff;
	assign ext_wdata = ext_wdata_ff;
	assign ctrl      = '{
		port_b_out:    io_ff[iod_pkg::OFS_PORT_B_OUT],
		port_b_dir:    io_ff[iod_pkg::OFS_PORT_B_DIR],
		port_c_out:    io_ff[iod_pkg::OFS_PORT_C_OUT],
		port_c_dir:    io_ff[iod_pkg::OFS_PORT_C_DIR],
		port_d_out:    io_ff[iod_pkg::OFS_PORT_D_OUT],
		port_d_dir:    io_ff[iod_pkg::OFS_PORT_D_DIR],
		ee_addr_lo:    io_ff[iod_pkg::OFS_EE_ADDR_LO],
		ee_addr_hi:    io_ff[iod_pkg::OFS_EE_ADDR_HI],
		gen_timer_ctl: io_ff[iod_pkg::OFS_GEN_TIMER_CTL],
		t0_ctl_a:      io_ff[iod_pkg::OFS_T0_CTL_A],
		t0_ctl_b:      io_ff[iod_pkg::OFS_T0_CTL_B],
		t0_count:      io_ff[iod_pkg::OFS_T0_COUNT],
		t0_cmp_a:      io_ff[iod_pkg::OFS_T0_CMP_A],
		t0_cmp_b:      io_ff[iod_pkg::OFS_T0_CMP_B],
		scratch_one:   io_ff[iod_pkg::OFS_SCRATCH_ONE],
		scratch_two:   io_ff[iod_pkg::OFS_SCRATCH_TWO],
		spi_ctl:       io_ff[iod_pkg::OFS_SPI_CTL],
		spi_data:      io_ff[iod_pkg::OFS_SPI_DATA],
		cmp_ctl:       io_ff[iod_pkg::OFS_CMP_CTL_STATE],
		sleep_ctl:     io_ff[iod_pkg::OFS_SLEEP_CTL]
	};

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [7:0] t0_flags;
	logic [7:0] pb_out;
	logic       skip_ref;
	logic [2:0] t0_events;

	assign t0_flags  = io_ff[iod_pkg::OFS_T0_FLAGS];
	assign pb_out    = io_ff[iod_pkg::OFS_PORT_B_OUT];
	assign skip_ref  = io_ff[addr][req.bit_sel];
	assign t0_events = {events.t0_cmp_b, events.t0_cmp_a, events.t0_ovf};

	chk_io_answer: assert property (@(posedge clk) disable iff (!rstn)
		take && op_io |=> ans_ff.ack && !ext_req_ff)
		else $error("I/O access not answered in one cycle");

	chk_ext_route: assert property (@(posedge clk) disable iff (!rstn)
		take && mem_ext |=> ext_req_ff && !ans_ff.ack ##1 ans_ff.ack)
		else $error("Extended access not routed to the outside port");

	chk_bit_refused: assert property (@(posedge clk) disable iff (!rstn)
		take && op_bit && !bit_ok |=> ans_ff.refused && $stable(pb_out))
		else $error("Bit operation above 0x1f was not refused");

	chk_skip_result: assert property (@(posedge clk) disable iff (!rstn)
		take && req.op == iod_pkg::skip_when_io_bit_high && bit_ok
		|=> ans_ff.skip == $past(skip_ref))
		else $error("Skip result does not match the tested bit");

	chk_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
		take && req.op == iod_pkg::io_write_op
		&& req.io_addr == iod_pkg::OFS_T0_FLAGS && t0_events == 3'b000
		|=> t0_flags == ($past(t0_flags) & ~($past(req.wdata) & 8'h07)))
		else $error("Flag write did not clear exactly the written ones");

	chk_bit_single: assert property (@(posedge clk) disable iff (!rstn)
		take && req.op == iod_pkg::set_io_bit_op
		&& req.io_addr == iod_pkg::OFS_T0_FLAGS && t0_events == 3'b000
		|=> t0_flags == ($past(t0_flags) & ~$past(sel_mask)))
		else $error("Bit operation disturbed neighbouring flags");

	chk_bit_set_port: assert property (@(posedge clk) disable iff (!rstn)
		take && req.op == iod_pkg::set_io_bit_op
		&& req.io_addr == iod_pkg::OFS_PORT_B_OUT
		|=> pb_out == ($past(pb_out) | $past(sel_mask)))
		else $error("Bit set did not reach the port output");

	chk_data_offset: assert property (@(posedge clk) disable iff (!rstn)
		take && req.op == iod_pkg::memory_write_direct
		&& req.data_addr == 8'h25 |=> pb_out == $past(req.wdata))
		else $error("Data-space write missed its I/O location");

	chk_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
		take && req.op == iod_pkg::io_read_op && req.io_addr == 6'h00
		|=> ans_ff.rdata == 8'h00)
		else $error("Reserved location did not read zero");
endmodule // iod_top

/* inc/iod_pkg.sv */
// Purpose: Constants, types and decode helpers of the I/O register space.
// Assumes: One 125 MHz clock, asynchronous active-low reset.
// Notes:   I/O addresses are 6 bits; data-space addresses are 8 bits.
package iod_pkg;

	// ------------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------------
	localparam logic [5:0] IO_SPAN_LAST       = 6'h3f;
	localparam logic [5:0] BIT_SPAN_LAST      = 6'h1f;
	localparam logic [7:0] DATA_IO_OFFSET     = 8'h20;
	localparam logic [7:0] DATA_IO_LAST       = 8'h5f;
	localparam logic [7:0] DATA_EXT_FIRST     = 8'h60;

	localparam logic [5:0] OFS_PORT_B_PIN     = 6'h03;
	localparam logic [5:0] OFS_PORT_B_DIR     = 6'h04;
	localparam logic [5:0] OFS_PORT_B_OUT     = 6'h05;
	localparam logic [5:0] OFS_PORT_C_PIN     = 6'h06;
	localparam logic [5:0] OFS_PORT_C_DIR     = 6'h07;
	localparam logic [5:0] OFS_PORT_C_OUT     = 6'h08;
	localparam logic [5:0] OFS_PORT_D_PIN     = 6'h09;
	localparam logic [5:0] OFS_PORT_D_DIR     = 6'h0a;
	localparam logic [5:0] OFS_PORT_D_OUT     = 6'h0b;
	localparam logic [5:0] OFS_T0_FLAGS       = 6'h15;
	localparam logic [5:0] OFS_T2_FLAGS       = 6'h17;
	localparam logic [5:0] OFS_EE_ADDR_LO     = 6'h21;
	localparam logic [5:0] OFS_EE_ADDR_HI     = 6'h22;
	localparam logic [5:0] OFS_GEN_TIMER_CTL  = 6'h23;
	localparam logic [5:0] OFS_T0_CTL_A       = 6'h24;
	localparam logic [5:0] OFS_T0_CTL_B       = 6'h25;
	localparam logic [5:0] OFS_T0_COUNT       = 6'h26;
	localparam logic [5:0] OFS_T0_CMP_A       = 6'h27;
	localparam logic [5:0] OFS_T0_CMP_B       = 6'h28;
	localparam logic [5:0] OFS_SCRATCH_ONE    = 6'h2a;
	localparam logic [5:0] OFS_SCRATCH_TWO    = 6'h2b;
	localparam logic [5:0] OFS_SPI_CTL        = 6'h2c;
	localparam logic [5:0] OFS_SPI_STATE      = 6'h2d;
	localparam logic [5:0] OFS_SPI_DATA       = 6'h2e;
	localparam logic [5:0] OFS_CMP_CTL_STATE  = 6'h30;
	localparam logic [5:0] OFS_SLEEP_CTL      = 6'h33;

	// ------------------------------------------------------------------
	// Field positions and reset value
	// ------------------------------------------------------------------
	localparam int         POS_FLAG_OVF       = 0;
	localparam int         POS_FLAG_CMP_A     = 1;
	localparam int         POS_FLAG_CMP_B     = 2;
	localparam int         POS_SPI_DONE       = 7;
	localparam int         POS_SPI_COLLIDE    = 6;
	localparam int         POS_CMP_OUT        = 5;
	localparam int         POS_CMP_EDGE       = 4;
	localparam int         POS_FORCE_A        = 7;
	localparam int         POS_FORCE_B        = 6;
	localparam logic [7:0] REG_RESET          = 8'h00;
	localparam logic [7:0] PORT_C_PIN_MASK    = 8'h7f;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		io_read_op,
		io_write_op,
		set_io_bit_op,
		clear_io_bit_op,
		skip_when_io_bit_high,
		skip_when_io_bit_low,
		memory_read_direct,
		memory_write_direct
	} iod_op_t;

	typedef struct packed {
		logic       valid;
		iod_op_t    op;
		logic [5:0] io_addr;
		logic [7:0] data_addr;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
	} iod_req_t;

	typedef struct packed {
		logic       ack;
		logic [7:0] rdata;
		logic       skip;
		logic       refused;
	} iod_ans_t;

	typedef struct packed {
		logic t0_ovf;
		logic t0_cmp_a;
		logic t0_cmp_b;
		logic t2_ovf;
		logic t2_cmp_a;
		logic t2_cmp_b;
		logic spi_done;
		logic spi_collide;
		logic cmp_edge;
	} iod_events_t;

	typedef struct packed {
		logic [7:0] port_b_out;
		logic [7:0] port_b_dir;
		logic [7:0] port_c_out;
		logic [7:0] port_c_dir;
		logic [7:0] port_d_out;
		logic [7:0] port_d_dir;
		logic [7:0] ee_addr_lo;
		logic [7:0] ee_addr_hi;
		logic [7:0] gen_timer_ctl;
		logic [7:0] t0_ctl_a;
		logic [7:0] t0_ctl_b;
		logic [7:0] t0_count;
		logic [7:0] t0_cmp_a;
		logic [7:0] t0_cmp_b;
		logic [7:0] scratch_one;
		logic [7:0] scratch_two;
		logic [7:0] spi_ctl;
		logic [7:0] spi_data;
		logic [7:0] cmp_ctl;
		logic [7:0] sleep_ctl;
	} iod_ctrl_t;

	// ------------------------------------------------------------------
	// Per-address bit classes
	// ------------------------------------------------------------------
	// Bits that software stores; all others read zero unless live or a set flag.
	function automatic logic [7:0] rw_mask(input logic [5:0] a);
		case (a)
			OFS_PORT_B_DIR, OFS_PORT_B_OUT,
			OFS_PORT_D_DIR, OFS_PORT_D_OUT,
			OFS_EE_ADDR_LO, OFS_EE_ADDR_HI,
			OFS_T0_COUNT, OFS_T0_CMP_A, OFS_T0_CMP_B,
			OFS_SCRATCH_ONE, OFS_SCRATCH_TWO,
			OFS_SPI_CTL, OFS_SPI_DATA:   rw_mask = 8'hff;
			OFS_PORT_C_DIR, OFS_PORT_C_OUT: rw_mask = 8'h7f;
			OFS_GEN_TIMER_CTL:           rw_mask = 8'h83;
			OFS_T0_CTL_A:                rw_mask = 8'hf3;
			OFS_T0_CTL_B:                rw_mask = 8'h0f;
			OFS_SPI_STATE:               rw_mask = 8'h01;
			OFS_CMP_CTL_STATE:           rw_mask = 8'hcf;
			OFS_SLEEP_CTL:               rw_mask = 8'h0f;
			default:                     rw_mask = 8'h00;
		endcase
	endfunction

	// Flags that a written one clears.
	function automatic logic [7:0] w1c_mask(input logic [5:0] a);
		case (a)
			OFS_T0_FLAGS, OFS_T2_FLAGS:  w1c_mask = 8'h07;
			OFS_SPI_STATE:               w1c_mask = 8'hc0;
			OFS_CMP_CTL_STATE:           w1c_mask = 8'h10;
			default:                     w1c_mask = 8'h00;
		endcase
	endfunction

endpackage : iod_pkg

/* hdl/iod_pin_sync.sv */
// Purpose: Brings asynchronous pin levels into the clock domain.
// Assumes: Inputs may change at any time relative to clk.
// Notes:   A bit changes only once the second and third stages agree.
module iod_pin_sync #(
	parameter int WIDTH = 24
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] level_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
		end else begin
			stage1_ff <= pin_in;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// Holding on disagreement rejects a single-cycle glitch.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			level_ff <= '0;
		end else begin
			level_ff <= (stage2_ff & stage3_ff)
				| (level_ff & (stage2_ff ^ stage3_ff));
		end
	end

	assign pin_out = level_ff;
endmodule // iod_pin_sync

/* hdl/iod_bit_alu.sv */
// Purpose: Computes the new value of one I/O location for a write.
// Assumes: Masks come from the address decode of the caller.
// Notes:   Purely combinational.
module iod_bit_alu (
	input  wire logic [7:0] old_val,
	input  wire logic [7:0] rw_bits,
	input  wire logic [7:0] w1c_bits,
	input  wire logic       bit_mode,
	input  wire logic       bit_set,
	input  wire logic [2:0] bit_sel,
	input  wire logic [7:0] wdata,
	output logic      [7:0] sel_mask,
	output logic      [7:0] new_val,
	output logic            bit_test
);
	logic [7:0] val;

	always_comb begin
		sel_mask = bit_mode ? (8'h01 << bit_sel) : 8'hff;
		val      = bit_mode ? {8{bit_set}} : wdata;
		// A bit operation touches only the selected bit, so it never
		// writes a one onto a neighbouring flag.
		new_val  = (old_val & ~(rw_bits & sel_mask))
			| (val & rw_bits & sel_mask);
		new_val  = new_val & ~(val & w1c_bits & sel_mask);
		bit_test = old_val[bit_sel];
	end
endmodule // iod_bit_alu

/* bench/iod_core_model.sv */
// Purpose: Stands in for the processor core that issues I/O requests.
// Assumes: One request at a time; answers come back on ans.ack.
// Notes:   Drives at the falling edge so the rising edge sees it settled.
module iod_core_model (
	input  wire logic              clk,
	output iod_pkg::iod_req_t      req,
	input  wire iod_pkg::iod_ans_t ans
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	// ------------------------------------------------------------------
	// Request issue
	// ------------------------------------------------------------------
	// Valid is a per-cycle level, so it stands for exactly one rising
	// edge; holding it longer would be taken as a second request.
	task automatic op(input iod_pkg::iod_op_t o, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d,
		output iod_pkg::iod_ans_t r);
		int n;
		n = 0;
		@(negedge clk);
		req <= '{1'b1, o, a[5:0], a, b, d};
		@(negedge clk);
		req <= '0;
		while (ans.ack !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		r = ans;
	endtask
endmodule // iod_core_model

/* bench/tb.sv */
// Purpose: Self-checking bench of the I/O space decoder.
// Assumes: Core model issues requests; bench drives pins and events.
// Notes:   Expected values come from the register map, not the design.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 clk       = 1'b0;
	logic                 rstn      = 1'b0;
	iod_pkg::iod_events_t events    = '0;
	logic [7:0]           pb        = 8'h00;
	logic [6:0]           pc        = 7'h00;
	logic [7:0]           pd        = 8'h00;
	logic                 cmp_lvl   = 1'b0;
	logic [7:0]           busy_seen = 8'h00;
	logic [1:0]           force_hit = 2'b00;
	logic [7:0]           ext_rdata = 8'h00;
	iod_pkg::iod_req_t    req;
	iod_pkg::iod_ans_t    ans;
	iod_pkg::iod_ans_t    r;
	iod_pkg::iod_ctrl_t   ctrl;
	logic                 busy;
	logic                 ext_req;
	logic                 ext_we;
	logic [7:0]           ext_addr;
	logic [7:0]           ext_wdata;
	logic [1:0]           force_cmp;
	logic [16:0]          ext_seen  = '0;
	int                   err_total = 0;
	int                   checked   = 0;

	always #4 clk = ~clk;

	iod_top iod_top_inst (.clk(clk), .rstn(rstn), .req(req), .ans(ans),
		.busy(busy), .events(events), .port_b_pins(pb), .port_c_pins(pc),
		.port_d_pins(pd), .cmp_level(cmp_lvl), .ctrl(ctrl),
		.force_cmp(force_cmp), .ext_req(ext_req), .ext_we(ext_we),
		.ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

	iod_core_model iod_core_model_inst (.clk(clk), .req(req), .ans(ans));

	// Pulses stand for one cycle, so they are caught at the falling edge.
	always @(negedge clk) begin
		if (ext_req === 1'b1)
			ext_seen = {ext_we, ext_addr, ext_wdata};
		if (busy === 1'b1)
			busy_seen = busy_seen + 8'h01;
		if (force_cmp !== 2'b00)
			force_hit = force_cmp;
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic io(input iod_pkg::iod_op_t o, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d);
		iod_core_model_inst.op(o, a, b, d, r);
		check({7'h00, r.ack}, 8'h01);
	endtask

	task automatic complete_run();
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_rw();
		io(iod_pkg::io_read_op, 8'h2a, 3'h0, 8'h00);
		check(r.rdata, iod_pkg::REG_RESET);
		io(iod_pkg::io_write_op, 8'h2a, 3'h0, 8'ha5);
		io(iod_pkg::io_read_op, 8'h2a, 3'h0, 8'h00);
		check(r.rdata, 8'ha5);
		io(iod_pkg::memory_read_direct, 8'h4a, 3'h0, 8'h00);
		check(r.rdata, 8'ha5);
		io(iod_pkg::memory_write_direct, 8'h4b, 3'h0, 8'h3c);
		check(ctrl.scratch_two, 8'h3c);
	endtask

	// Reserved places are only read; written force bits strobe once and go out as zero.
	task automatic t_reserved();
		io(iod_pkg::io_read_op, 8'h29, 3'h0, 8'h00);
		check(r.rdata, 8'h00);
		io(iod_pkg::io_read_op, 8'h00, 3'h0, 8'h00);
		check(r.rdata, 8'h00);
		io(iod_pkg::io_write_op, 8'h08, 3'h0, 8'h7f);
		io(iod_pkg::io_read_op, 8'h08, 3'h0, 8'h00);
		check(r.rdata, 8'h7f);
		io(iod_pkg::io_write_op, 8'h25, 3'h0, 8'h81);
		@(negedge clk);
		check({6'h00, force_hit}, 8'h02);
		check(ctrl.t0_ctl_b, 8'h01);
	endtask

	task automatic t_bits();
		io(iod_pkg::memory_write_direct, 8'h25, 3'h0, 8'h5a);
		check(ctrl.port_b_out, 8'h5a);
		io(iod_pkg::set_io_bit_op, 8'h05, 3'h0, 8'h00);
		check(ctrl.port_b_out, 8'h5b);
		io(iod_pkg::clear_io_bit_op, 8'h05, 3'h6, 8'h00);
		check(ctrl.port_b_out, 8'h1b);
		io(iod_pkg::skip_when_io_bit_high, 8'h05, 3'h1, 8'h00);
		check({7'h00, r.skip}, 8'h01);
		io(iod_pkg::skip_when_io_bit_low, 8'h05, 3'h2, 8'h00);
		check({7'h00, r.skip}, 8'h01);
		io(iod_pkg::set_io_bit_op, 8'h2a, 3'h1, 8'h00);
		check({6'h00, r.refused, r.skip}, 8'h02);
		check(ctrl.scratch_one, 8'ha5);
	endtask

	task automatic t_flags();
		@(negedge clk);
		events.t0_ovf = 1'b1;
		events.t0_cmp_b = 1'b1;
		@(negedge clk);
		events = '0;
		io(iod_pkg::io_write_op, 8'h15, 3'h0, 8'h00);
		io(iod_pkg::io_read_op, 8'h15, 3'h0, 8'h00);
		check(r.rdata, 8'h05);
		io(iod_pkg::set_io_bit_op, 8'h15, 3'h0, 8'h00);
		io(iod_pkg::io_read_op, 8'h15, 3'h0, 8'h00);
		check(r.rdata, 8'h04);
		io(iod_pkg::io_write_op, 8'h15, 3'h0, 8'h04);
		io(iod_pkg::io_read_op, 8'h15, 3'h0, 8'h00);
		check(r.rdata, 8'h00);
	endtask

	task automatic t_ext();
		ext_rdata = 8'h96;
		io(iod_pkg::memory_write_direct, 8'h80, 3'h0, 8'h11);
		check(ext_seen[15:8], 8'h80);
		check({ext_seen[16], ext_seen[6:0]}, 8'h91);
		io(iod_pkg::memory_read_direct, 8'hff, 3'h0, 8'h00);
		check(r.rdata, 8'h96);
		check({ext_seen[16], ext_seen[15:9]}, 8'h7f);
		check(busy_seen, 8'h02);
	endtask

	task automatic t_pins();
		@(negedge clk);
		pb = 8'hc3;
		pc = 7'h55;
		pd = 8'h96;
		cmp_lvl = 1'b1;
		repeat (6) @(negedge clk);
		io(iod_pkg::io_read_op, 8'h03, 3'h0, 8'h00);
		check(r.rdata, 8'hc3);
		io(iod_pkg::memory_read_direct, 8'h26, 3'h0, 8'h00);
		check(r.rdata, 8'h55);
		io(iod_pkg::io_read_op, 8'h09, 3'h0, 8'h00);
		check(r.rdata, 8'h96);
		io(iod_pkg::io_read_op, 8'h30, 3'h0, 8'h00);
		check(r.rdata, 8'h20);
	endtask

	// ------------------------------------------------------------------
	// Sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		t_rw();
		t_reserved();
		t_bits();
		t_flags();
		t_ext();
		t_pins();
		complete_run();
	end

	// The tests need under a hundred cycles; 2000 cycles means a hang.
	initial begin
		repeat (2000) @(posedge clk);
		err_total++;
		complete_run();
	end
endmodule // tb
